// File: logic/bcm_multiplier.sv
// Count-and-shift BCD multiplier, 4 x 4 digits, with an Avalon-MM slave.
// Notes on behaviour
// - Two 4-digit BCD factors give an 8-digit product in 16 partial steps.
// - Partial products are counted into an 8-decade counter; loads shift it.
// - A whole multiplication stays under 300 us; overrun is flagged.
// - Idle keeps both flags reset and the shift counter loaded, top bit high.
// - Idle leaves the previous product untouched in the result counter.
// - A start rise sets run, shows busy, clears digit and result counters.
// - Shift counter then steps to zero; factor counters count from complements.
// - Second-factor terminal during init loads the shift counter with 15.
// - That same terminal sets the clear-release flag, ending init.
// - Shift counter at 15 reloads both factor counters with complemented digits.
// - First-factor terminal reloads it and steps the second-factor counter unless full.
// - Result counts each partial-product clock unless a factor counter is full.
// - Second-factor terminal steps digit select and loads 15: one decade down.
// - The shift clock reloads factor counters and takes the shift counter to 0.
// - After the last first-factor digit load 10: six down rotations instead.
// - Digit select wrapping 15 to 0 resets run and freezes the product.
// - Busy follows the run flag and drops with the final digit-select wrap.
`timescale 1ns/100ps
module bcm_multiplier
  import bcm_pkg::*;
#(
  parameter logic [ELAPSED_W-1:0] RUN_LIMIT = 16'(RUN_LIMIT_CYC)
)(
  input  wire  logic                 mclk,            // System clock.
  input  wire  logic                 rst,             // Async reset, high.
  input  wire  logic                 start,           // Start request pin.
  output logic                       busy,            // Multiply running.
  output logic [PRODUCT_W-1:0]       product,         // BCD product.
  input  wire  logic [ADDR_W-1:0]    avs_address,     // Byte address.
  input  wire  logic                 avs_read,        // Read request.
  input  wire  logic                 avs_write,       // Write request.
  input  wire  logic [31:0]          avs_writedata,   // Write data.
  input  wire  logic [3:0]           avs_byteenable,  // Byte lanes.
  output logic [31:0]                avs_readdata,    // Read data.
  output logic                       avs_waitrequest  // Stall, high.
);

  // Sequencer state and counters.
  bcm_state_t            state_r;
  bcm_state_t            state_nxt;
  logic [3:0]            a_r;          // First-factor counter.
  logic [3:0]            a_nxt;
  logic [3:0]            b_r;          // Second-factor counter.
  logic [3:0]            b_nxt;
  logic [3:0]            c_r;          // Digit-select counter.
  logic [3:0]            c_nxt;
  logic [3:0]            d_r;          // Shift-control counter.
  logic [3:0]            d_nxt;
  logic [FACTOR_W-1:0]   factor_a_r;
  logic [FACTOR_W-1:0]   factor_b_r;
  logic [ELAPSED_W-1:0]  elapsed_r;
  logic                  overtime_r;

  // Start synchroniser.
  logic                  start_s1_r;
  logic                  start_s2_r;
  logic                  start_s3_r;
  logic                  start_lvl_r;

  // Bus slave registers.
  logic                  wait_r;
  logic [31:0]           rdata_r;

  // Decoded control terms.
  logic                  run_flag;
  logic                  clear_release_flag;
  logic                  first_factor_terminal;
  logic                  second_factor_terminal;
  logic                  digit_select_terminal;
  logic                  parallel_load_enable;
  logic                  master_clear;
  logic                  counting;
  logic                  pp_end;
  logic                  c_step;
  logic                  finish;
  logic                  r_count;
  logic                  r_shift;
  logic                  last_a;
  logic [3:0]            digit_a;
  logic [3:0]            digit_b;
  logic                  start_stable;
  logic                  pin_go;
  logic                  sw_go;
  logic                  start_req;
  logic                  bus_req;
  logic                  wr_commit;
  logic                  rd_capture;
  logic                  sel_ctrl;
  logic                  sel_status;
  logic                  sel_fa;
  logic                  sel_fb;
  logic                  sel_prod;
  logic                  factor_wr_ok;
  logic [31:0]           status_word;
  logic [31:0]           rd_mux;
  logic [3:0]            r_q [DECADES];
  logic [DECADES:0]      carry;

  // The two control flip-flops are the two state bits.
  assign run_flag           = state_r[0];
  assign clear_release_flag = state_r[1];
  assign busy               = run_flag;

  // Counter terminal decodes.
  assign first_factor_terminal  = (a_r == CNT_FULL);
  assign second_factor_terminal = (b_r == CNT_FULL);
  assign digit_select_terminal  = (c_r == CNT_FULL);

  // Factor digit selection: low pair of C picks A, high pair picks B.
  assign digit_a = factor_a_r[{c_r[1:0], 2'b00} +: DIGIT_W];
  assign digit_b = factor_b_r[{c_r[3:2], 2'b00} +: DIGIT_W];
  assign last_a  = (c_r[1:0] == LAST_A_DIGIT);

  // Phase decodes for the counters.
  assign parallel_load_enable = run_flag & (d_r == D_LOAD_DOWN1);
  assign counting     = run_flag & (d_r == CNT_ZERO);
  assign pp_end       = counting & second_factor_terminal;
  assign c_step       = pp_end & clear_release_flag;
  assign finish       = c_step & digit_select_terminal;
  assign master_clear = run_flag & ~clear_release_flag;
  assign r_count      = clear_release_flag & counting &
                        ~first_factor_terminal &
                        ~second_factor_terminal;
  assign r_shift      = clear_release_flag & d_r[D_TOP_BIT];

  // Start from the pin edge or a software go bit; ignored unless idle.
  assign start_stable = (start_s2_r == start_s3_r);
  assign pin_go       = start_stable & start_s3_r & ~start_lvl_r;
  assign sw_go        = wr_commit & sel_ctrl & avs_byteenable[0] &
                        avs_writedata[CTRL_GO_BIT];
  assign start_req    = (pin_go | sw_go) & ~run_flag;

  // Control flag sequencing.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        if (pp_end) begin
          state_nxt = ST_MULT;
        end
      end
      ST_MULT: begin
        if (finish) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Shift-control counter: held loaded while idle, counts while top bit high.
  assign d_nxt = !run_flag ? D_LOAD_DOWN1 :
                 pp_end ? ((clear_release_flag & last_a) ?
                           D_LOAD_UP2 :
                           D_LOAD_DOWN1) :
                 d_r[D_TOP_BIT] ? d_r + CNT_ONE :
                 d_r;

  // First-factor counter reloads at its terminal or on the shift clock.
  assign a_nxt = (parallel_load_enable |
                  (counting & first_factor_terminal)) ?
                 ~digit_a :
                 counting ? a_r + CNT_ONE : a_r;

  // Second-factor counter steps on each first-factor terminal unless it is full.
  assign b_nxt = parallel_load_enable ? ~digit_b :
                 (counting & first_factor_terminal &
                  ~second_factor_terminal) ? b_r + CNT_ONE :
                 b_r;

  // Digit select is cleared during init and steps per partial product.
  assign c_nxt = master_clear ? CNT_ZERO :
                 c_step ? c_r + CNT_ONE :
                 c_r;

  // Sequencer registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      a_r     <= CNT_ZERO;
      b_r     <= CNT_ZERO;
      c_r     <= CNT_ZERO;
      d_r     <= D_LOAD_DOWN1;
    end else begin
      state_r <= state_nxt;
      a_r     <= a_nxt;
      b_r     <= b_nxt;
      c_r     <= c_nxt;
      d_r     <= d_nxt;
    end
  end

  // Result counter: eight decades, carries upward, shifts down as a ring.
  assign carry[0] = r_count;
  genvar gi;
  generate
    for (gi = 0; gi < DECADES; gi++) begin : g_dec
      bcm_decade_if dif ();
      assign dif.clr      = master_clear;
      assign dif.shift    = r_shift;
      assign dif.cin      = carry[gi];
      assign dif.shift_in = r_q[(gi + 1) % DECADES];
      assign carry[gi+1]  = dif.cout;
      assign r_q[gi]      = dif.q;
      bcm_decade u_decade (
        .mclk (mclk),
        .rst  (rst),
        .dif  (dif)
      );
    end
  endgenerate

  // The finished product sits rotated by two decades; unrotate by wiring.
  assign product = {r_q[1], r_q[0], r_q[7], r_q[6],
                    r_q[5], r_q[4], r_q[3], r_q[2]};

  // Start pin synchroniser and debounced level.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_s1_r  <= 1'b0;
      start_s2_r  <= 1'b0;
      start_s3_r  <= 1'b0;
      start_lvl_r <= 1'b0;
    end else begin
      start_s1_r  <= start;
      start_s2_r  <= start_s1_r;
      start_s3_r  <= start_s2_r;
      if (start_stable) begin
        start_lvl_r <= start_s3_r;
      end
    end
  end

  // Run time watchdog: counts busy cycles and flags an overrun.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      elapsed_r  <= ELAPSED_CLR;
      overtime_r <= 1'b0;
    end else if (start_req) begin
      elapsed_r  <= ELAPSED_CLR;
      overtime_r <= 1'b0;
    end else if (run_flag) begin
      if (elapsed_r == RUN_LIMIT) begin
        overtime_r <= 1'b1;
      end else begin
        elapsed_r <= elapsed_r + ELAPSED_ONE;
      end
    end
  end

  // Bus decode: one wait cycle, then the access completes.
  assign bus_req      = avs_read | avs_write;
  assign wr_commit    = avs_write & ~wait_r;
  assign rd_capture   = avs_read & wait_r;
  assign sel_ctrl     = (avs_address == ADDR_CTRL);
  assign sel_status   = (avs_address == ADDR_STATUS);
  assign sel_fa       = (avs_address == ADDR_FACTOR_A);
  assign sel_fb       = (avs_address == ADDR_FACTOR_B);
  assign sel_prod     = (avs_address == ADDR_PRODUCT);
  assign factor_wr_ok = wr_commit & ~run_flag;

  // Read data selection; unmapped addresses read zero.
  assign status_word  = {29'h0000_0000, clear_release_flag,
                         overtime_r, run_flag};
  assign rd_mux = sel_status ? status_word :
                  sel_fa     ? {16'h0000, factor_a_r} :
                  sel_fb     ? {16'h0000, factor_b_r} :
                  sel_prod   ? product :
                  WORD_ZERO;

  // Bus handshake and read data register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_r  <= 1'b1;
      rdata_r <= WORD_ZERO;
    end else begin
      wait_r <= ~(bus_req & wait_r);
      if (rd_capture) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  // Factor registers, byte-lane writable only while idle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      factor_a_r <= 16'h0000;
      factor_b_r <= 16'h0000;
    end else if (factor_wr_ok) begin
      if (sel_fa & avs_byteenable[0]) begin
        factor_a_r[7:0] <= avs_writedata[7:0];
      end
      if (sel_fa & avs_byteenable[1]) begin
        factor_a_r[15:8] <= avs_writedata[15:8];
      end
      if (sel_fb & avs_byteenable[0]) begin
        factor_b_r[7:0] <= avs_writedata[7:0];
      end
      if (sel_fb & avs_byteenable[1]) begin
        factor_b_r[15:8] <= avs_writedata[15:8];
      end
    end
  end

endmodule // bcm_multiplier

// File: logic/bcm_pkg.sv
// Shared constants and types for the count-and-shift BCD multiplier.
package bcm_pkg;

  // Operand and result geometry.
  localparam int DIGITS      = 4;
  localparam int DECADES     = 8;
  localparam int DIGIT_W     = 4;
  localparam int PRODUCT_W   = DECADES * DIGIT_W;
  localparam int FACTOR_W    = DIGITS * DIGIT_W;

  // Counter values used by the sequencer.
  localparam logic [3:0] CNT_FULL     = 4'hF;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;
  localparam logic [3:0] D_LOAD_DOWN1 = 4'hF;
  localparam logic [3:0] D_LOAD_UP2   = 4'hA;
  localparam logic [3:0] BCD_MAX      = 4'h9;
  localparam int         D_TOP_BIT    = 3;
  localparam logic [1:0] LAST_A_DIGIT = 2'h3;

  // Avalon-MM byte addresses of the register words.
  localparam int         ADDR_W        = 5;
  localparam logic [4:0] ADDR_CTRL     = 5'h00;
  localparam logic [4:0] ADDR_STATUS   = 5'h04;
  localparam logic [4:0] ADDR_FACTOR_A = 5'h08;
  localparam logic [4:0] ADDR_FACTOR_B = 5'h0C;
  localparam logic [4:0] ADDR_PRODUCT  = 5'h10;

  // Field positions.
  localparam int CTRL_GO_BIT      = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_OVER_BIT    = 1;
  localparam int STAT_CLRREL_BIT  = 2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Run time ceiling, converted to clock cycles (longest time rounds down).
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_US     = 1000;
  localparam int RUN_LIMIT_US  = 300;
  localparam int RUN_LIMIT_CYC = RUN_LIMIT_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int ELAPSED_W     = 16;
  localparam logic [15:0] ELAPSED_ONE = 16'h0001;
  localparam logic [15:0] ELAPSED_CLR = 16'h0000;

  // Control flag pair: bit 0 is the run flag, bit 1 the clear-release flag.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INIT = 2'b01,
    ST_MULT = 2'b11
  } bcm_state_t;

endpackage

// File: logic/bcm_decade_if.sv
// Control and status bundle between the sequencer and one result decade.
`timescale 1ns/100ps
interface bcm_decade_if;
  logic       clr;       // Synchronous clear to zero.
  logic       shift;     // Load from the neighbouring decade.
  logic       cin;       // Count enable / carry in.
  logic [3:0] shift_in;  // Neighbour value for a shift.
  logic [3:0] q;         // Current decade value.
  logic       cout;      // Carry out on a 9 to 0 roll.

  modport dec (input clr, input shift, input cin, input shift_in,
               output q, output cout);
  modport ctl (output clr, output shift, output cin, output shift_in,
               input q, input cout);
endinterface

// File: logic/bcm_decade.sv
// One synchronous BCD decade of the result counter with parallel load.
`timescale 1ns/100ps
module bcm_decade
  import bcm_pkg::*;
(
  input  wire logic mclk,       // System clock.
  input  wire logic rst,        // Asynchronous reset, active high.
  bcm_decade_if.dec dif         // Decade control and status.
);

  logic [3:0] q_r;
  logic [3:0] q_nxt;
  logic       at_max;

  // Clear wins over load, load wins over count.
  assign at_max   = (q_r == BCD_MAX);
  assign q_nxt    = dif.clr   ? CNT_ZERO :
                    dif.shift ? dif.shift_in :
                    dif.cin   ? (at_max ? CNT_ZERO : q_r + CNT_ONE) :
                    q_r;
  assign dif.q    = q_r;
  assign dif.cout = dif.cin & at_max & ~dif.shift & ~dif.clr;

  // Decade storage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= CNT_ZERO;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule // bcm_decade

// File: verification/bcm_monitor.sv
// Port-level assertion checker for the BCD multiplier.
`timescale 1ns/100ps
module bcm_monitor
  import bcm_pkg::*;
(
  input wire logic                 mclk,            // System clock.
  input wire logic                 rst,             // Async reset, high.
  input wire logic                 start,           // Start request pin.
  input wire logic                 busy,            // Multiply running.
  input wire logic [PRODUCT_W-1:0] product,         // BCD product.
  input wire logic                 avs_read,        // Read request.
  input wire logic                 avs_write,       // Write request.
  input wire logic [31:0]          avs_readdata,    // Read data.
  input wire logic                 avs_waitrequest  // Stall, high.
);
  localparam logic [15:0] MAX_RUN = 16'(RUN_LIMIT_CYC);
  logic [15:0] run_cnt_r;

  // Counts the clocks of the current run so its length can be bounded.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) run_cnt_r <= 16'h0000;
    else if (busy) run_cnt_r <= run_cnt_r + 16'h0001;
    else run_cnt_r <= 16'h0000;
  end

  // All checks share the system clock and its reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("Bus request got no answer after one cycle.");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("Waitrequest stayed low for more than one cycle.");
  property p_wait_idle;
    !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("Waitrequest dropped with no request.");
  property p_rdata_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");
  property p_prod_idle;
    !busy ##1 !busy |-> $stable(product);
  endproperty
  a_prod_idle: assert property (p_prod_idle)
    else $error("Product changed while idle.");
  property p_busy_min;
    $rose(busy) |=> busy [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("Run ended too early for sixteen partial products.");
  property p_busy_bound;
    busy |-> run_cnt_r < MAX_RUN;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("Run lasted beyond the time limit.");
  property p_pin_start;
    $rose(start) && !busy |-> ##[3:5] busy;
  endproperty
  a_pin_start: assert property (p_pin_start)
    else $error("Start pin rise did not raise busy.");
endmodule // bcm_monitor

bind bcm_multiplier bcm_monitor u_mon (.mclk, .rst, .start, .busy, .product,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);

// File: verification/bcm_requester.sv
// Requesting logic model that drives the start pin.
`timescale 1ns/100ps
module bcm_requester (
  input  wire logic mclk,  // System clock.
  output logic      start  // Start request pin.
);
  // Start idles low so that a later rise counts as a request.
  initial start = 1'b0;

  // Raises start for the given clocks, then keeps it low long enough.
  task automatic pulse(input int hold);
    @(posedge mclk);
    start <= 1'b1;
    repeat (hold) @(posedge mclk);
    start <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule // bcm_requester

// File: verification/testbench.sv
// Self-checking testbench for the count-and-shift BCD multiplier.
`timescale 1ns/100ps
module testbench import bcm_pkg::*;;
  logic        mclk    = 1'b0;
  logic        rst     = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read    = 1'b0;
  logic        write   = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  be      = 4'hF;
  logic        start;
  logic        busy;
  logic        wreq;
  logic [31:0] product;
  logic [31:0] rdata;
  int          failures = 0;
  int          checked  = 0;
  int          cyc      = 0;
  int          seed     = 33485;

  // Clock at 25 MHz.
  always #20 mclk = ~mclk;

  bcm_requester req (.mclk(mclk), .start(start));
  bcm_multiplier #(.RUN_LIMIT(16'h07D0)) dut (.mclk(mclk), .rst(rst),
    .start(start), .busy(busy), .product(product), .avs_address(address),
    .avs_read(read), .avs_write(write), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq));

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      complete_run;
    end
  end

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h, want %h", $time, g, e);
    end
  endtask

  task automatic cmp_flag(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: flag %b, want %b", $time, g, e);
    end
  endtask

  // Reference model: BCD to integer and back.
  function automatic int from_bcd(input logic [15:0] v);
    int r = 0;
    for (int i = 3; i >= 0; i--) r = r * 10 + int'(v[4*i+:4]);
    return r;
  endfunction

  function automatic logic [31:0] to_bcd(input int v);
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      r[4*i+:4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  function automatic logic [15:0] rnd_bcd();
    logic [15:0] r;
    for (int i = 0; i < 4; i++) r[4*i+:4] = 4'({$random(seed)} % 10);
    return r;
  endfunction

  // One Avalon access; held until waitrequest is sampled low.
  task automatic av(input bit rd, input logic [4:0] a,
                    input logic [31:0] w, output logic [31:0] q);
    @(posedge mclk);
    address <= a;
    read <= rd;
    write <= !rd;
    wdata <= w;
    // Only the bench timeout may end this wait.
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Full multiplication, started by pin or register, optionally meddled.
  task automatic mult(input logic [15:0] a, input logic [15:0] b,
                      input bit pin, input bit meddle);
    logic [31:0] d;
    logic [31:0] e;
    int          n = 0;
    e = to_bcd(from_bcd(a) * from_bcd(b));
    av(0, ADDR_FACTOR_A, {16'h0000, a}, d);
    av(0, ADDR_FACTOR_B, {16'h0000, b}, d);
    if (pin) req.pulse(3);
    else av(0, ADDR_CTRL, 32'h0000_0001, d);
    while (busy !== 1'b1 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    cmp_flag(busy, 1'b1);
    if (meddle) begin
      av(0, ADDR_FACTOR_A, 32'h0000_1111, d);
      av(0, ADDR_CTRL, 32'h0000_0001, d);
      req.pulse(20);
    end
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    cmp_word(product, e);
    av(1, ADDR_PRODUCT, 32'h0, d);
    cmp_word(d, e);
    av(1, ADDR_STATUS, 32'h0, d);
    cmp_word(d, 32'h0000_0000);
    av(1, ADDR_FACTOR_A, 32'h0, d);
    cmp_word(d, {16'h0000, a});
    $display("Test %h x %h done", a, b);
  endtask

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [15:0] fa [6];
    logic [15:0] fb [6];
    fa = '{16'h0000, 16'h9999, 16'h1234, 16'h0001, 16'h9999, 16'h0705};
    fb = '{16'h0000, 16'h9999, 16'h5678, 16'h0001, 16'h0000, 16'h8080};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp_flag(busy, 1'b0);
    cmp_word(product, 32'h0);
    cmp_flag(wreq, 1'b1);
    av(1, 5'h14, 32'h0, d);
    cmp_word(d, 32'h0);
    av(1, ADDR_CTRL, 32'h0, d);
    cmp_word(d, 32'h0);
    // A write with only the low byte lane enabled lands in that lane only.
    be <= 4'h1;
    av(0, ADDR_FACTOR_A, 32'h0000_4321, d);
    be <= 4'hF;
    av(1, ADDR_FACTOR_A, 32'h0, d);
    cmp_word(d, 32'h0000_0021);
    $display("Test reset and map done");
    for (int i = 0; i < 6; i++) mult(fa[i], fb[i], i[0], i == 1);
    for (int i = 0; i < 4; i++) mult(rnd_bcd(), rnd_bcd(), i[0], 1'b0);
    d = product;
    repeat (50) @(posedge mclk);
    cmp_word(product, d);
    av(0, ADDR_FACTOR_A, 32'h0000_5678, d);
    av(0, ADDR_CTRL, 32'h0000_0001, d);
    repeat (30) @(posedge mclk);
    cmp_flag(busy, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp_flag(busy, 1'b0);
    cmp_word(product, 32'h0);
    cmp_flag(wreq, 1'b1);
    rst <= 1'b0;
    av(1, ADDR_FACTOR_A, 32'h0, d);
    cmp_word(d, 32'h0);
    $display("Test mid-run reset done");
    mult(16'h0042, 16'h0010, 1'b0, 1'b0);
    complete_run;
  end
endmodule // testbench
